/* apr_cal_file.sv */
`timescale 1ns/10ps
module apr_cal_file #(
    parameter int N = apr_pkg::NCAL,   // register count
    parameter int W = apr_pkg::CW      // stored width
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [1:0]   sel_i,    // calibration select code
    input  wire logic         clr_i,    // pointer back to group start
    input  wire logic         adv_i,    // one access finished
    input  wire logic         we_i,     // store at pointer
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] rdata_o
);
    logic [W-1:0] mem_r [N];  // coefficient storage
    logic [3:0]   ptr_r;      // access pointer

    // first register of the group chosen by the select code
    function automatic logic [3:0] grp_first(input logic [1:0] s);
        grp_first = (s == apr_pkg::CSEL_OFS) ? apr_pkg::CIX_OFFS : apr_pkg::CIX_GAIN;
    endfunction : grp_first

    // last register of the group
    function automatic logic [3:0] grp_last(input logic [1:0] s);
        case (s)
            apr_pkg::CSEL_FULL: grp_last = apr_pkg::CIX_LAST;
            apr_pkg::CSEL_GO:   grp_last = apr_pkg::CIX_OFFS;
            apr_pkg::CSEL_OFS:  grp_last = apr_pkg::CIX_OFFS;
            default:            grp_last = apr_pkg::CIX_GAIN;
        endcase
    endfunction : grp_last

    ////////////////////////////////////////////////////////////////////
    // pointer: clear wins, wraps to start once the group is done
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_r <= apr_pkg::CIX_GAIN;
        end else if (clr_i) begin
            ptr_r <= grp_first(sel_i);
        end else if (adv_i) begin
            if (ptr_r == grp_last(sel_i)) begin
                ptr_r <= grp_first(sel_i);
            end else begin
                ptr_r <= ptr_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one storage word per index
    for (genvar i = 0; i < N; i++) begin : g_reg
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                mem_r[i] <= '0;
            end else if (we_i && ptr_r == 4'(i)) begin
                mem_r[i] <= wdata_i;
            end
        end
    end

    assign rdata_o = mem_r[ptr_r];  // pointer never leaves 0..N-1
endmodule : apr_cal_file

/* apr_host_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// host processor on the byte bus; each request is held across edges
module apr_host_model (
    input  wire logic        clk_i,
    input  wire logic [11:0] data_lines_i,     // lines driven by the device
    output logic             cs_b_o,
    output logic             rd_b_o,
    output logic             wr_b_o,
    output logic             upper_byte_sel_o,
    output logic [11:0]      data_lines_o,
    output logic             rd_done_o,        // one-cycle note per read
    output logic [11:0]      rd_data_o
);
    // idle bus: strobes and select high
    initial begin
        {cs_b_o, rd_b_o, wr_b_o, upper_byte_sel_o, rd_done_o} = 5'h1C;
        data_lines_o = 12'h000;
        rd_data_o = 12'h000;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // one byte; lines show junk once released so stale data cannot pass
    task automatic put_byte(input logic hi, input logic [7:0] b, input logic cs);
        cs_b_o <= ~cs;
        upper_byte_sel_o <= hi;
        data_lines_o <= {4'h0, b};
        wr_b_o <= 1'b0;
        cyc(4);
        wr_b_o <= 1'b1;
        cyc(4);
        cs_b_o <= 1'b1;
        data_lines_o <= ~data_lines_o;
        cyc(4);
    endtask : put_byte
    // low byte first, then high byte
    task automatic write_word(input logic [15:0] w, input logic cs);
        put_byte(1'b0, w[7:0], cs);
        put_byte(1'b1, w[15:8], cs);
    endtask : write_word
    // read is sampled at the edge just before the strobes let go
    task automatic read(input logic hi);
        cs_b_o <= 1'b0;
        rd_b_o <= 1'b0;
        upper_byte_sel_o <= hi;
        cyc(7);
        rd_data_o <= data_lines_i;
        rd_done_o <= 1'b1;
        cyc(1);
        rd_done_o <= 1'b0;
        {cs_b_o, rd_b_o} <= 2'h3;
        cyc(4);
    endtask : read
endmodule : apr_host_model

/* apr_pkg.sv */
package apr_pkg;
    // pin and register widths
    localparam int DW      = 12;              // data line count
    localparam int CW      = 14;              // stored word width
    localparam int WW      = 16;              // host word width
    localparam int BW      = 8;               // byte lane width
    localparam int NCAL    = 10;              // calibration register count
    localparam int CNT_W   = 17;              // phase tick counter width
    // target field of a written word
    localparam int TGT_HI  = 15;
    localparam int TGT_LO  = 14;
    localparam logic [1:0] TGT_TEST = 2'h1;
    localparam logic [1:0] TGT_CAL  = 2'h2;
    localparam logic [1:0] TGT_CTRL = 2'h3;
    // read source codes share the target encoding
    localparam logic [1:0] SRC_RESULT = 2'h0;
    localparam logic [1:0] SRC_TEST   = 2'h1;
    localparam logic [1:0] SRC_CAL    = 2'h2;
    localparam logic [1:0] SRC_STATUS = 2'h3;
    // control word fields
    localparam int B_PWR_HI   = 9;
    localparam int B_PWR_LO   = 8;
    localparam int B_RS_HI    = 7;
    localparam int B_RS_LO    = 6;
    localparam int B_RANGE    = 5;
    localparam int B_SWCONV   = 4;
    localparam int B_CALKIND  = 3;
    localparam int B_CSEL_HI  = 2;
    localparam int B_CSEL_LO  = 1;
    localparam int B_LAUNCH   = 0;
    localparam logic [CW-1:0] CTRL_RST = 14'h0000;
    localparam logic [1:0]    STAT_ONES = 2'h3;  // status bits 7..6
    // calibration select codes
    localparam logic [1:0] CSEL_FULL = 2'h0;
    localparam logic [1:0] CSEL_GO   = 2'h1;
    localparam logic [1:0] CSEL_OFS  = 2'h2;
    localparam logic [1:0] CSEL_GAIN = 2'h3;
    // calibration register indices
    localparam logic [3:0] CIX_GAIN = 4'h0;
    localparam logic [3:0] CIX_OFFS = 4'h1;
    localparam logic [3:0] CIX_LAST = 4'h9;
    // sync vector layout and idle value (strobes high, sleep high)
    localparam int NSY = 7;
    localparam logic [NSY-1:0] SYNC_IDLE = 7'h4F;
    // durations in master clock ticks
    localparam int CONV_TICKS     = 16;
    localparam int CAL_FULL_TICKS = 125013;
    localparam int CAL_OFFS_TICKS = 13899;
    localparam int CAL_GAIN_TICKS = 13899;
    localparam int CAL_DAC_TICKS  = CAL_FULL_TICKS - CAL_OFFS_TICKS - CAL_GAIN_TICKS;
    typedef enum logic [1:0] {PH_IDLE, PH_DAC, PH_GAIN, PH_OFFS} apr_phase_t;
endpackage : apr_pkg

/* apr_top.sv */
// How it works
// - trigger rising edge starts hold and conversion
// - busy rises on trigger fall, clears when done
// - bus ignored unless chip select is low
// - upper byte select chooses byte on lines
// - low byte-select read returns twelve low bits
// - top two word bits pick target register
// - read-select bits pick the read source
// - read source persists; resets to conversion result
// - result read has four leading zero bits
// - power bits with sleep pin pick power-down
// - range bit: unipolar binary or bipolar
// - software start bit self-clears at conversion end
// - calibration kind bit: self or system
// - launch bit starts calibration, self-clears after
// - without launch, select bits address coefficients
// - self calibration sequence per select code
// - system calibration sequence per select code
// - read-only sixteen bit status word
// - status top six zero, then settings
// - status bits seven and six read one
// - status busy bit mirrors activity
// - coefficient pointer advances, control write resets
`timescale 1ns/10ps
module apr_top #(
    parameter int CONV_TICKS     = apr_pkg::CONV_TICKS,
    parameter int CAL_DAC_TICKS  = apr_pkg::CAL_DAC_TICKS,
    parameter int CAL_GAIN_TICKS = apr_pkg::CAL_GAIN_TICKS,
    parameter int CAL_OFFS_TICKS = apr_pkg::CAL_OFFS_TICKS
) (
    input  wire logic                  CLK_I,
    input  wire logic                  RST_B_I,
    input  wire logic                  CONV_TRIG_B_I,
    input  wire logic                  RD_B_I,
    input  wire logic                  WR_B_I,
    input  wire logic                  CS_B_I,
    input  wire logic                  UPPER_BYTE_SEL_I,
    input  wire logic [apr_pkg::DW-1:0] DATA_LINES_I,
    input  wire logic                  MASTER_CLOCK_IN_I,
    input  wire logic                  SLEEP_B_I,
    input  wire logic [apr_pkg::DW-1:0] ADC_RESULT_I,
    output logic      [apr_pkg::DW-1:0] DATA_LINES_O,
    output logic                       DATA_LINES_OE_O,
    output logic                       BUSY_O,
    output logic                       HOLD_O,
    output logic                       RANGE_BIPOLAR_O,
    output logic      [1:0]            POWER_CTL_O,
    output logic                       POWER_DOWN_O,
    output logic                       CAL_SYSTEM_O,
    output apr_pkg::apr_phase_t        CAL_PHASE_O
);
    localparam int DW = apr_pkg::DW;
    localparam int CW = apr_pkg::CW;
    localparam int NS = apr_pkg::NSY + DW;  // synced bits
    localparam logic [NS-1:0] S_IDLE = {apr_pkg::SYNC_IDLE, {DW{1'b0}}};

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser; stage 1 feeds stage 2 only
    logic [NS-1:0] s1_r;   // first stage
    logic [NS-1:0] s2_r;   // usable stage
    logic [NS-1:0] p_r;    // one cycle older, for edges
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s1_r <= S_IDLE;
            s2_r <= S_IDLE;
            p_r  <= S_IDLE;
        end else begin
            s1_r <= {SLEEP_B_I, MASTER_CLOCK_IN_I, UPPER_BYTE_SEL_I, CS_B_I,
                     WR_B_I, RD_B_I, CONV_TRIG_B_I, DATA_LINES_I};
            s2_r <= s1_r;
            p_r  <= s2_r;
        end
    end

    logic          trig_s, trig_p, rd_s, rd_p, wr_s, wr_p, cs_s, cs_p;
    logic          upper_byte_select_s, upper_byte_select_p, mclk_s, mclk_p, sleep_b_s;
    logic [DW-1:0] data_p;  // data as it stood while the strobe was low
    assign {sleep_b_s, mclk_s, upper_byte_select_s, cs_s, wr_s, rd_s, trig_s} = s2_r[NS-1:DW];
    assign {mclk_p, upper_byte_select_p, cs_p, wr_p, rd_p, trig_p} = p_r[NS-2:DW];
    assign data_p = p_r[DW-1:0];

    // edge events; strobe ends count only with chip select low
    logic trig_rise, trig_fall, wr_done, rd_done, mclk_tick;
    assign trig_rise = trig_s & ~trig_p;
    assign trig_fall = ~trig_s & trig_p;
    assign wr_done   = wr_s & ~wr_p & ~cs_p;
    assign rd_done   = rd_s & ~rd_p & ~cs_p;
    assign mclk_tick = mclk_s & ~mclk_p;

    ////////////////////////////////////////////////////////////////////
    // byte staging: low byte waits for the high byte
    logic [apr_pkg::BW-1:0] stage_r;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            stage_r <= '0;
        end else if (wr_done && !upper_byte_select_p) begin
            stage_r <= data_p[apr_pkg::BW-1:0];
        end
    end

    logic [apr_pkg::WW-1:0] word;   // assembled host word
    logic [1:0]             tgt;    // its target code
    logic                   word_wr, ctrl_wr, test_wr, cal_wr;
    assign word    = {data_p[apr_pkg::BW-1:0], stage_r};
    assign word_wr = wr_done & upper_byte_select_p;
    assign tgt     = word[apr_pkg::TGT_HI:apr_pkg::TGT_LO];
    assign ctrl_wr = word_wr && tgt == apr_pkg::TGT_CTRL;
    assign test_wr = word_wr && tgt == apr_pkg::TGT_TEST;
    assign cal_wr  = word_wr && tgt == apr_pkg::TGT_CAL;

    ////////////////////////////////////////////////////////////////////
    // control and test registers
    logic [CW-1:0] ctrl_r;      // write-only settings
    logic [CW-1:0] test_r;      // test scratch
    logic          conv_done;   // conversion finishes this cycle
    logic          cal_done;    // calibration finishes this cycle
    logic [1:0]    src;         // read source
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_r <= apr_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            // a fresh write wins over the self-clears below
            ctrl_r <= word[CW-1:0];
        end else begin
            if (conv_done) begin
                ctrl_r[apr_pkg::B_SWCONV] <= 1'b0;
            end
            if (cal_done) begin
                ctrl_r[apr_pkg::B_LAUNCH] <= 1'b0;
            end
        end
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            test_r <= '0;
        end else if (test_wr) begin
            test_r <= word[CW-1:0];
        end
    end
    assign src = ctrl_r[apr_pkg::B_RS_HI:apr_pkg::B_RS_LO];

    ////////////////////////////////////////////////////////////////////
    // conversion: hardware or software start, timed on master clock
    logic                 conv_act_r, cal_act, conv_start, busy_r;
    logic [apr_pkg::CNT_W-1:0] conv_cnt_r;  // shares the phase counter width
    logic [DW-1:0]        result_r;
    assign conv_start = (trig_rise | (ctrl_wr & word[apr_pkg::B_SWCONV]))
                        & ~conv_act_r & ~cal_act;
    assign conv_done  = conv_act_r & mclk_tick & (conv_cnt_r == '0);
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            conv_act_r <= 1'b0;
            conv_cnt_r <= '0;
        end else if (conv_start) begin
            conv_act_r <= 1'b1;
            conv_cnt_r <= apr_pkg::CNT_W'(CONV_TICKS - 1);
        end else if (conv_done) begin
            conv_act_r <= 1'b0;
        end else if (conv_act_r && mclk_tick) begin
            conv_cnt_r <= conv_cnt_r - 1'b1;
        end
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            result_r <= '0;
        end else if (conv_done) begin
            result_r <= ADC_RESULT_I;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // calibration sequencer
    apr_pkg::apr_phase_t    phase_r;
    logic [apr_pkg::CNT_W-1:0] ph_cnt_r;
    logic [2:0]             cal_cfg_r;   // kind and select, held for the run
    logic                   cal_start, ph_end;
    apr_pkg::apr_phase_t    ph_next;
    // first phase for a select code, same order for self and system
    function automatic apr_pkg::apr_phase_t first_ph(input logic [1:0] s);
        case (s)
            apr_pkg::CSEL_FULL: first_ph = apr_pkg::PH_DAC;
            apr_pkg::CSEL_OFS:  first_ph = apr_pkg::PH_OFFS;
            default:            first_ph = apr_pkg::PH_GAIN;
        endcase
    endfunction : first_ph
    // ticks minus one for a phase
    function automatic logic [apr_pkg::CNT_W-1:0] ph_len(input apr_pkg::apr_phase_t p);
        case (p)
            apr_pkg::PH_DAC:  ph_len = apr_pkg::CNT_W'(CAL_DAC_TICKS - 1);
            apr_pkg::PH_GAIN: ph_len = apr_pkg::CNT_W'(CAL_GAIN_TICKS - 1);
            default:          ph_len = apr_pkg::CNT_W'(CAL_OFFS_TICKS - 1);
        endcase
    endfunction : ph_len
    assign cal_act   = phase_r != apr_pkg::PH_IDLE;
    assign cal_start = ctrl_wr & word[apr_pkg::B_LAUNCH] & ~cal_act & ~conv_act_r;
    assign ph_end    = cal_act & mclk_tick & (ph_cnt_r == '0);
    // gain-only ends after gain; every other gain goes on to offset
    always_comb begin
        case (phase_r)
            apr_pkg::PH_DAC:  ph_next = apr_pkg::PH_GAIN;
            apr_pkg::PH_GAIN: ph_next = (cal_cfg_r[1:0] == apr_pkg::CSEL_GAIN)
                                        ? apr_pkg::PH_IDLE : apr_pkg::PH_OFFS;
            default:          ph_next = apr_pkg::PH_IDLE;
        endcase
    end
    assign cal_done = ph_end && ph_next == apr_pkg::PH_IDLE;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            phase_r   <= apr_pkg::PH_IDLE;
            ph_cnt_r  <= '0;
            cal_cfg_r <= '0;
        end else if (cal_start) begin
            phase_r   <= first_ph(word[apr_pkg::B_CSEL_HI:apr_pkg::B_CSEL_LO]);
            ph_cnt_r  <= ph_len(first_ph(word[apr_pkg::B_CSEL_HI:apr_pkg::B_CSEL_LO]));
            cal_cfg_r <= word[apr_pkg::B_CALKIND:apr_pkg::B_CSEL_LO];
        end else if (ph_end) begin
            phase_r  <= ph_next;
            ph_cnt_r <= ph_len(ph_next);
        end else if (cal_act && mclk_tick) begin
            ph_cnt_r <= ph_cnt_r - 1'b1;
        end
    end
    // busy: set on trigger fall or any start, dropped at the end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (busy_r & ~(conv_done | cal_done))
                      | trig_fall | conv_start | cal_start;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // coefficient storage; select bits address it with or without launch
    logic [CW-1:0] cal_rd;
    logic          cal_adv;
    logic [1:0]    csel_now;   // new code, so a control write restarts in the new group
    assign cal_adv = cal_wr | (rd_done & upper_byte_select_p & (src == apr_pkg::SRC_CAL));
    assign csel_now = ctrl_wr ? word[apr_pkg::B_CSEL_HI:apr_pkg::B_CSEL_LO]
                              : ctrl_r[apr_pkg::B_CSEL_HI:apr_pkg::B_CSEL_LO];
    apr_cal_file u_cal (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .sel_i   (csel_now),
        .clr_i   (ctrl_wr),
        .adv_i   (cal_adv),
        .we_i    (cal_wr),
        .wdata_i (word[CW-1:0]),
        .rdata_o (cal_rd)
    );

    ////////////////////////////////////////////////////////////////////
    // read path: data registered, enable follows synced strobes
    logic [apr_pkg::WW-1:0] stat_w, rd_word;
    logic [DW-1:0]          dout_r;
    assign stat_w = {6'h00, ctrl_r[apr_pkg::B_PWR_HI:apr_pkg::B_PWR_LO],
                     apr_pkg::STAT_ONES, ctrl_r[apr_pkg::B_RANGE],
                     busy_r, ctrl_r[apr_pkg::B_CALKIND:apr_pkg::B_LAUNCH]};
    always_comb begin
        case (src)
            apr_pkg::SRC_RESULT: rd_word = {4'h0, result_r};
            apr_pkg::SRC_TEST:   rd_word = {2'h0, test_r};
            apr_pkg::SRC_CAL:    rd_word = {2'h0, cal_rd};
            default:             rd_word = stat_w;
        endcase
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            dout_r <= '0;
        end else if (upper_byte_select_s) begin
            dout_r <= {4'h0, rd_word[apr_pkg::WW-1:apr_pkg::BW]};
        end else begin
            dout_r <= rd_word[DW-1:0];
        end
    end
    assign DATA_LINES_O    = dout_r;
    assign DATA_LINES_OE_O = ~cs_s & ~rd_s;

    ////////////////////////////////////////////////////////////////////
    // settings and power state toward the converter
    logic pd_r;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pd_r <= 1'b0;
        end else begin
            case (ctrl_r[apr_pkg::B_PWR_HI:apr_pkg::B_PWR_LO])
                2'h0:    pd_r <= ~sleep_b_s;
                2'h1:    pd_r <= 1'b1;
                2'h2:    pd_r <= ~busy_r;
                default: pd_r <= ~busy_r & ~sleep_b_s;
            endcase
        end
    end
    assign BUSY_O          = busy_r;
    assign HOLD_O          = conv_act_r;
    assign RANGE_BIPOLAR_O = ctrl_r[apr_pkg::B_RANGE];
    assign POWER_CTL_O     = ctrl_r[apr_pkg::B_PWR_HI:apr_pkg::B_PWR_LO];
    assign POWER_DOWN_O    = pd_r;
    assign CAL_SYSTEM_O    = cal_cfg_r[2];
    assign CAL_PHASE_O     = phase_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_busy_on_fall: assert property (trig_fall |=> BUSY_O)
        else $error("busy not raised after trigger fall");
    a_hold_on_rise: assert property (trig_rise && !cal_act |=> HOLD_O)
        else $error("no hold after trigger rise");
    a_no_cs_quiet: assert property (cs_s |-> !DATA_LINES_OE_O)
        else $error("lines driven without chip select");
    a_ctrl_stored: assert property (ctrl_wr |=> ctrl_r == $past(word[CW-1:0]))
        else $error("control word not stored");
    a_src_holds: assert property (!ctrl_wr |=> $stable(src))
        else $error("read source moved without control write");
    a_result_pad: assert property (src == apr_pkg::SRC_RESULT && upper_byte_select_s && !ctrl_wr
        |=> DATA_LINES_O[DW-1:4] == '0)
        else $error("result high read not zero padded");
    a_status_ones: assert property (src == apr_pkg::SRC_STATUS && !upper_byte_select_s
        |=> DATA_LINES_O[7:6] == 2'h3 && DATA_LINES_O[4] == $past(busy_r))
        else $error("status ones or busy wrong");
    a_swconv_clear: assert property (conv_done && !ctrl_wr |=> !ctrl_r[apr_pkg::B_SWCONV])
        else $error("software start not cleared");
    a_launch_clear: assert property (cal_done && !ctrl_wr |=> !ctrl_r[apr_pkg::B_LAUNCH])
        else $error("launch not cleared");
    a_full_seq: assert property (cal_start && word[2:1] == apr_pkg::CSEL_FULL
        |=> phase_r == apr_pkg::PH_DAC)
        else $error("full calibration not started with dac");
    a_busy_done: assert property (conv_done && !trig_fall && !cal_act |=> !BUSY_O)
        else $error("busy stuck after conversion");
    c_conv: cover property (conv_done);
    c_cal: cover property (cal_done);
    c_cal_read: cover property (cal_adv && !cal_wr);
    c_status: cover property (src == apr_pkg::SRC_STATUS && DATA_LINES_OE_O);
endmodule : apr_top

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                trig_b = 1'b1;
    logic                sleep_b = 1'b1;
    logic                mclk = 1'b0;
    logic [11:0]         adc = 12'h000;
    logic [11:0]         dq_i, dq_o, rdat;
    logic                cs_b, rd_b, wr_b, ub, busy, hold, rng, pdn, csys, done, oe;
    logic [1:0]          pwr, f;
    logic [15:0]         st;
    apr_pkg::apr_phase_t ph;
    logic [11:0]         exp_q[$];         // expected read values, oldest first
    int                  n_fail = 0;
    int                  compares = 0;
    int                  seed = 32'hb822_a948;
    int                  cycles = 0;
    always #25 clk = ~clk;
    // master clock at half rate; phases long enough to be read mid-run
    always @(posedge clk) mclk <= ~mclk;
    apr_top #(.CONV_TICKS(4), .CAL_DAC_TICKS(20), .CAL_GAIN_TICKS(20), .CAL_OFFS_TICKS(20)) dut (
        .CLK_I(clk), .RST_B_I(rst_b), .CONV_TRIG_B_I(trig_b), .RD_B_I(rd_b),
        .WR_B_I(wr_b), .CS_B_I(cs_b), .UPPER_BYTE_SEL_I(ub), .DATA_LINES_I(dq_i),
        .MASTER_CLOCK_IN_I(mclk), .SLEEP_B_I(sleep_b), .ADC_RESULT_I(adc),
        .DATA_LINES_O(dq_o), .DATA_LINES_OE_O(oe), .BUSY_O(busy), .HOLD_O(hold),
        .RANGE_BIPOLAR_O(rng), .POWER_CTL_O(pwr), .POWER_DOWN_O(pdn),
        .CAL_SYSTEM_O(csys), .CAL_PHASE_O(ph));
    apr_host_model host (.clk_i(clk), .data_lines_i(dq_o), .cs_b_o(cs_b), .rd_b_o(rd_b),
        .wr_b_o(wr_b), .upper_byte_sel_o(ub), .data_lines_o(dq_i), .rd_done_o(done),
        .rd_data_o(rdat));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic hi, input logic [11:0] e);
        exp_q.push_back(e);
        host.read(hi);
    endtask : rd
    // bounded wait, then the level itself is compared
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 300 && busy !== v; i++) @(posedge clk);
        check(16'(busy), 16'(v));
    endtask : wait_busy
    // read monitor: each finished read retires the oldest note
    always @(posedge clk) begin
        if (done) check({4'h0, rdat}, {4'h0, exp_q.pop_front()});
        if (done) check(16'(oe), 16'h0001);
    end
    // hang guard: far above the roughly 1400 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        adc <= 12'($random(seed));
        trig_b <= 1'b0;
        repeat (5) @(posedge clk);
        check(16'(busy), 16'h0001);
        trig_b <= 1'b1;
        repeat (5) @(posedge clk);
        check(16'(hold), 16'h0001);
        wait_busy(1'b0);
        rd(1'b0, adc);
        rd(1'b1, {4'h0, 4'h0, adc[11:8]});
        $display("test trigger conversion done");
        // random settings, read back through status in both byte halves
        repeat (4) begin
            sleep_b <= 1'($random(seed));
            st = {6'h00, 2'($random(seed)), 2'h3, 1'($random(seed)), 1'b0, 3'($random(seed)), 1'b0};
            host.write_word({2'h3, st[13:0]}, 1'b1);
            rd(1'b0, st[11:0]);
            rd(1'b1, {4'h0, st[15:8]});
            check(16'(rng), 16'(st[5]));
            check(16'(pwr), 16'(st[9:8]));
            check(16'(pdn), 16'((st[9] ^ st[8]) | !sleep_b));
        end
        // deselected write and empty target both leave state alone
        host.write_word({2'h3, st[13:6], ~st[5], st[4:0]}, 1'b0);
        host.write_word({2'h0, st[13:6], ~st[5], st[4:0]}, 1'b1);
        check(16'(oe), 16'h0000);
        rd(1'b0, st[11:0]);
        st = {2'h1, 14'($random(seed))};
        host.write_word(st, 1'b1);
        host.write_word(16'hC040, 1'b1);
        rd(1'b0, st[11:0]);
        $display("test register decode done");
        adc <= 12'($random(seed));
        host.write_word(16'hC0D0, 1'b1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(1'b0, 12'h0C0);
        host.write_word(16'hC000, 1'b1);
        rd(1'b0, adc);
        $display("test software start done");
        // every kind and select code; phase seen mid-run, status mid-run for full select and after each
        for (int k = 0; k < 8; k++) begin
            host.write_word({2'h3, 6'h00, 2'h3, 2'h0, 3'(k), 1'b1}, 1'b1);
            wait_busy(1'b1);
            repeat (2) @(posedge clk);
            f = (k[1:0] == 2'h0) ? 2'h1 : (k[1:0] == 2'h2) ? 2'h3 : 2'h2;
            check(16'(csys), 16'(k[2]));
            check(16'(ph), 16'(f));
            if (k[1:0] == 2'h0) rd(1'b0, {4'h0, 2'h3, 2'h1, 3'(k), 1'b1});
            wait_busy(1'b0);
            rd(1'b0, {4'h0, 2'h3, 2'h0, 3'(k), 1'b0});
        end
        $display("test calibration done");
        // two-word group written, then offset alone and the group read back
        st = {2'h2, 14'($random(seed))};
        host.write_word(16'hC082, 1'b1);
        host.write_word(st, 1'b1);
        host.write_word({2'h2, ~st[13:0]}, 1'b1);
        host.write_word(16'hC084, 1'b1);
        rd(1'b0, ~st[11:0]);
        rd(1'b1, {6'h00, ~st[13:8]});
        host.write_word(16'hC082, 1'b1);
        rd(1'b0, st[11:0]);
        rd(1'b1, {6'h00, st[13:8]});
        rd(1'b0, ~st[11:0]);
        $display("test calibration registers done");
        repeat (3) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule : tb_top
